// ### rtl/imc_pkg.sv
package imc_pkg;

  // mode encoding, one-hot; the both-clear-but-extended code is never held
  typedef enum logic [2:0] {
    IMC_DIS = 3'b001,
    IMC_LEG = 3'b010,
    IMC_EXT = 3'b100
  } imc_state_e;

  // register-instruction address space
  localparam logic [31:0] IMC_MODE_BASE_ADDR = 32'h0000_0400;
  localparam logic [21:0] IMC_RANGE_TAG      = 22'h00_0002;
  localparam logic [25:0] IMC_EXT_TAG        = 26'h000_0020;
  localparam int          IMC_EN_BIT         = 11;
  localparam int          IMC_EXTENDED_MODE_BIT_BIT       = 10;
  localparam logic [63:0] IMC_BASE_MASK      = 64'h0000_0000_0000_0c00;

  // register indices (memory-mapped offset is index times 16)
  localparam logic [7:0] IMC_IX_ID        = 8'h02;
  localparam logic [7:0] IMC_IX_VER       = 8'h03;
  localparam logic [7:0] IMC_IX_TPR       = 8'h08;
  localparam logic [7:0] IMC_IX_LDR       = 8'h0d;
  localparam logic [7:0] IMC_IX_DFR       = 8'h0e;
  localparam logic [7:0] IMC_IX_SVR       = 8'h0f;
  localparam logic [7:0] IMC_IX_ISR       = 8'h10;
  localparam logic [7:0] IMC_IX_TMR       = 8'h18;
  localparam logic [7:0] IMC_IX_IRR       = 8'h20;
  localparam logic [7:0] IMC_IX_PEND_LAST = 8'h27;
  localparam logic [7:0] IMC_IX_ESR       = 8'h28;
  localparam logic [7:0] IMC_IX_CMCI      = 8'h2f;
  localparam logic [7:0] IMC_IX_ICR       = 8'h30;
  localparam logic [7:0] IMC_IX_ICR_HI    = 8'h31;
  localparam logic [7:0] IMC_IX_LVT_FIRST = 8'h32;
  localparam logic [7:0] IMC_IX_LVT_LAST  = 8'h37;
  localparam logic [7:0] IMC_IX_INIT      = 8'h38;
  localparam logic [7:0] IMC_IX_CUR       = 8'h39;
  localparam logic [7:0] IMC_IX_DCR       = 8'h3e;
  localparam logic [7:0] IMC_IX_SELF      = 8'h3f;
  localparam int         IMC_LVT_NUM      = 7;

  // writable-bit masks
  localparam logic [31:0] IMC_TPR_MASK    = 32'h0000_00ff;
  localparam logic [31:0] IMC_SVR_MASK    = 32'h0000_11ff;
  localparam logic [31:0] IMC_ICR_LO_MASK = 32'h000c_cfff;
  localparam logic [31:0] IMC_LVT_MASK    = 32'h0001_f7ff;
  localparam logic [31:0] IMC_DCR_MASK    = 32'h0000_000b;
  localparam logic [31:0] IMC_SELF_MASK   = 32'h0000_00ff;
  localparam logic [31:0] IMC_TOP8_MASK   = 32'hff00_0000;
  localparam logic [31:0] IMC_DFR_MASK    = 32'hf000_0000;

  // reset values
  localparam logic [31:0] IMC_SVR_RST = 32'h0000_00ff;
  localparam logic [31:0] IMC_DFR_RST = 32'hffff_ffff;
  localparam logic [31:0] IMC_LVT_RST = 32'h0001_0000;
  // arbitrary neutral value
  localparam logic [31:0] IMC_VERSION_DEFAULT = 32'h0000_0010;

  // transition-area entry check
  localparam logic [31:0] IMC_ENTRY_MASK  = 32'hffff_f800;
  localparam logic [31:0] IMC_ENTRY_MATCH = 32'h0000_0800;

  // apb map
  localparam logic [11:0] IMC_APB_STATUS = 12'h000;
  localparam logic [11:0] IMC_APB_MODE   = 12'h004;
  localparam logic [11:0] IMC_APB_ID     = 12'h008;
  localparam logic [11:0] IMC_APB_FCNT   = 12'h00c;
  localparam int          IMC_ST_FAULT   = 8;
  localparam int          IMC_ST_ENTRY   = 9;

endpackage

// ### rtl/imc_mode_ctrl.sv
// Behaviour
// - instruction access to the index range off extended mode faults
// - memory path in extended mode acts disabled
// - instruction accesses complete in program order
// - fail area entries in protected index range
// - enable and extended bits encode mode
// - write into invalid encoding faults
// - reset gives enabled legacy mode
// - reset loads identifier, low byte legacy
// - reset clears legacy fields, counters, self
// - vector entries cleared but masked; version kept
// - spurious vector ff, format all ones
// - legacy to extended keeps id, derives logical
// - legacy with enable cleared goes disabled
// - soft init in legacy keeps mode, id
// - extended only goes disabled; else fault
// - reset from extended/disabled fully reinitialises
// - soft init in extended keeps id
// - disabled only goes legacy; init stays
// - entering extended derives logical, reloads mmio id from id low byte, clears icr high
// - reserved nonzero write faults, reads zero
// - identifier read-only at index two
`timescale 1ns/100ps
module imc_mode_ctrl
  import imc_pkg::*;
#(
  parameter logic [31:0] VERSION_VALUE = IMC_VERSION_DEFAULT
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // identifier strap, caught after reset release
  input  wire logic [31:0] hw_id,
  // core access request
  input  wire logic        acc_valid,
  input  wire logic        acc_mmio,
  input  wire logic        acc_write,
  input  wire logic [31:0] acc_addr,
  input  wire logic [63:0] acc_wdata,
  // core access answer
  output logic             acc_done,
  output logic             acc_fault,
  output logic      [63:0] acc_rdata,
  // soft init
  input  wire logic        soft_init,
  // transition area entry check
  input  wire logic        entry_valid,
  input  wire logic        entry_exit,
  input  wire logic [31:0] area_entry_low_word,
  output logic             entry_done,
  output logic             entry_fail,
  output logic             entry_host_reload,
  output logic             entry_abort,
  // mode
  output logic             mode_enable,
  output logic             mode_extended
);

  imc_state_e  state_reg;
  logic        id_load_reg;
  logic [31:0] id_reg;
  logic [7:0]  mmio_id_reg;
  logic [31:0] ldr_reg;
  logic [31:0] tpr_reg;
  logic [31:0] dfr_reg;
  logic [31:0] svr_reg;
  logic [31:0] isr_reg;
  logic [31:0] tmr_reg;
  logic [31:0] irr_reg;
  logic [31:0] icr_lo_reg;
  logic [31:0] icr_hi_reg;
  logic [31:0] lvt_reg [IMC_LVT_NUM];
  logic [31:0] init_cnt_reg;
  logic [31:0] cur_cnt_reg;
  logic [31:0] dcr_reg;
  logic [31:0] self_reg;
  logic        fault_flag_reg;
  logic        entry_flag_reg;
  logic [15:0] fault_cnt_reg;

  // commit: legal pairs only (dis->leg, leg->ext/dis, ext->dis, same)
  function automatic logic trans_ok(imc_state_e st, logic en, logic ex);
    logic ok;
    ok = 1'b0;
    unique case (st)
      IMC_DIS: ok = !ex;
      IMC_LEG: ok = !ex || en;
      IMC_EXT: ok = (en == ex);
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic imc_state_e req_state(logic en, logic ex);
    return en ? (ex ? IMC_EXT : IMC_LEG) : IMC_DIS;
  endfunction

  function automatic logic [2:0] lvt_slot(logic [7:0] ix);
    return (ix == IMC_IX_CMCI) ? 3'd0 : 3'(ix - IMC_IX_LVT_FIRST + 8'h01);
  endfunction

  // hardware-derived logical id: cluster in upper half, one-hot low half
  function automatic logic [31:0] ldr_of(logic [31:0] id);
    return {id[19:4], 16'h0001 << id[3:0]};
  endfunction

  logic [7:0]  acc_ix;
  logic        legacy_view;
  logic [63:0] view_val;
  logic [63:0] view_mask;
  logic        view_known;
  logic        view_ro;
  logic        view_wo;

  assign acc_ix      = acc_mmio ? acc_addr[11:4] : acc_addr[7:0];
  assign legacy_view = acc_mmio;

  // per-register view: value, writable bits, direction
  always_comb begin
    view_val   = '0;
    view_mask  = '0;
    view_known = 1'b1;
    view_ro    = 1'b0;
    view_wo    = 1'b0;
    case (acc_ix) inside
      IMC_IX_ID: begin
        view_val  = legacy_view ? {32'h0, mmio_id_reg, 24'h0}
                                : {32'h0, id_reg};
        view_mask = legacy_view ? {32'h0, IMC_TOP8_MASK} : '0;
        view_ro   = !legacy_view;
      end
      IMC_IX_VER: begin
        view_val = {32'h0, VERSION_VALUE};
        view_ro  = 1'b1;
      end
      IMC_IX_TPR: begin
        view_val  = {32'h0, tpr_reg};
        view_mask = {32'h0, IMC_TPR_MASK};
      end
      IMC_IX_LDR: begin
        view_val  = {32'h0, ldr_reg};
        view_mask = legacy_view ? {32'h0, IMC_TOP8_MASK} : '0;
        view_ro   = !legacy_view;
      end
      IMC_IX_DFR: begin
        view_val   = {32'h0, dfr_reg};
        view_mask  = {32'h0, IMC_DFR_MASK};
        view_known = legacy_view;
      end
      IMC_IX_SVR: begin
        view_val  = {32'h0, svr_reg};
        view_mask = {32'h0, IMC_SVR_MASK};
      end
      [IMC_IX_ISR:IMC_IX_PEND_LAST]: begin
        view_val = (acc_ix == IMC_IX_ISR) ? {32'h0, isr_reg} :
                   (acc_ix == IMC_IX_TMR) ? {32'h0, tmr_reg} :
                   (acc_ix == IMC_IX_IRR) ? {32'h0, irr_reg} : 64'h0;
        view_ro  = 1'b1;
      end
      IMC_IX_ESR: view_mask = '0; // any nonzero instruction write faults
      IMC_IX_CMCI, [IMC_IX_LVT_FIRST:IMC_IX_LVT_LAST]: begin
        view_val  = {32'h0, lvt_reg[lvt_slot(acc_ix)]};
        view_mask = {32'h0, IMC_LVT_MASK};
      end
      IMC_IX_ICR: begin
        view_val  = legacy_view ? {32'h0, icr_lo_reg}
                                : {icr_hi_reg, icr_lo_reg};
        view_mask = legacy_view ? {32'h0, IMC_ICR_LO_MASK}
                                : {32'hffff_ffff, IMC_ICR_LO_MASK};
      end
      IMC_IX_ICR_HI: begin
        view_val   = {32'h0, icr_hi_reg};
        view_mask  = {32'h0, IMC_TOP8_MASK};
        view_known = legacy_view;
      end
      IMC_IX_INIT: begin
        view_val  = {32'h0, init_cnt_reg};
        view_mask = {32'h0, 32'hffff_ffff};
      end
      IMC_IX_CUR: begin
        view_val = {32'h0, cur_cnt_reg};
        view_ro  = 1'b1;
      end
      IMC_IX_DCR: begin
        view_val  = {32'h0, dcr_reg};
        view_mask = {32'h0, IMC_DCR_MASK};
      end
      IMC_IX_SELF: begin
        view_mask  = {32'h0, IMC_SELF_MASK};
        view_wo    = 1'b1;
        view_known = !legacy_view;
      end
      default: view_known = 1'b0;
    endcase
  end

  logic        is_base;
  logic        in_range;
  logic        ext_used;
  logic        base_bad;
  logic        base_wr;
  logic        core_mode_ok;
  logic        acc_bad;
  logic        wr_commit;
  logic [63:0] rd_value;
  logic [63:0] wd;

  assign is_base  = !acc_mmio && (acc_addr == IMC_MODE_BASE_ADDR);
  assign in_range = !acc_mmio && (acc_addr[31:10] == IMC_RANGE_TAG);
  assign ext_used = (acc_addr[31:6] == IMC_EXT_TAG);
  assign base_bad = |(acc_wdata & ~IMC_BASE_MASK);
  assign base_wr  = acc_valid && acc_write && is_base;
  assign core_mode_ok = !base_bad &&
      trans_ok(state_reg, acc_wdata[IMC_EN_BIT], acc_wdata[IMC_EXTENDED_MODE_BIT_BIT]);
  assign wd = acc_wdata & view_mask;

  // fault decision and read data for one core access
  always_comb begin
    acc_bad  = 1'b0;
    rd_value = '0;
    if (is_base) begin
      acc_bad  = acc_write && !core_mode_ok;
      rd_value = {52'h0, mode_enable, mode_extended, 10'h0};
    end else if (in_range) begin
      acc_bad = (state_reg != IMC_EXT) || !ext_used || !view_known ||
                (acc_write ? (view_ro || |(acc_wdata & ~view_mask))
                           : view_wo);
      rd_value = view_val;
    end else if (acc_mmio) begin
      rd_value = (state_reg == IMC_LEG && view_known) ? view_val : '0;
    end
  end

  // memory writes are masked silently, instruction writes only if clean
  assign wr_commit = acc_valid && acc_write && !soft_init && !acc_bad &&
                     (acc_mmio ? (state_reg == IMC_LEG && view_known)
                               : in_range);

  logic       apb_wr;
  logic       apb_mode_wr;
  logic       apb_mode_ok;
  logic       mode_commit;
  logic       new_en;
  logic       new_ex;
  imc_state_e new_state;
  logic       go_ext;
  logic       go_leg;

  assign apb_wr      = psel && penable && pready && pwrite;
  assign apb_mode_wr = apb_wr && (paddr == IMC_APB_MODE);
  assign apb_mode_ok = ~|(pwdata & ~IMC_BASE_MASK[31:0]) &&
      trans_ok(state_reg, pwdata[IMC_EN_BIT], pwdata[IMC_EXTENDED_MODE_BIT_BIT]);
  // core write wins a same-cycle clash; soft init blocks both
  assign new_en = base_wr ? acc_wdata[IMC_EN_BIT] : pwdata[IMC_EN_BIT];
  assign new_ex = base_wr ? acc_wdata[IMC_EXTENDED_MODE_BIT_BIT] : pwdata[IMC_EXTENDED_MODE_BIT_BIT];
  assign mode_commit = !soft_init &&
      (base_wr ? core_mode_ok : (apb_mode_wr && apb_mode_ok));
  assign new_state = req_state(new_en, new_ex);
  assign go_ext = mode_commit && state_reg == IMC_LEG && new_state == IMC_EXT;
  assign go_leg = mode_commit && state_reg == IMC_DIS && new_state == IMC_LEG;

  // mode machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= IMC_LEG;
      mode_enable   <= 1'b1;
      mode_extended <= 1'b0;
    end else if (mode_commit) begin
      state_reg     <= new_state;
      mode_enable   <= new_en;
      mode_extended <= new_ex;
    end
  end

  // identifier strap is sampled the cycle after reset releases
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      id_load_reg <= 1'b1;
      id_reg      <= '0;
    end else begin
      id_load_reg <= 1'b0;
      if (id_load_reg) begin
        id_reg <= hw_id;
      end
    end
  end

  // register file: reset, soft init, mode side effects, then writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mmio_id_reg  <= '0;
      ldr_reg      <= '0;
      tpr_reg      <= '0;
      dfr_reg      <= IMC_DFR_RST;
      svr_reg      <= IMC_SVR_RST;
      isr_reg      <= '0;
      tmr_reg      <= '0;
      irr_reg      <= '0;
      icr_lo_reg   <= '0;
      icr_hi_reg   <= '0;
      for (int i = 0; i < IMC_LVT_NUM; i++) begin
        lvt_reg[i] <= IMC_LVT_RST;
      end
      init_cnt_reg <= '0;
      cur_cnt_reg  <= '0;
      dcr_reg      <= '0;
      self_reg     <= '0;
    end else if (id_load_reg) begin
      mmio_id_reg <= hw_id[7:0];
    end else if (soft_init || go_leg) begin
      if (go_leg) begin
        mmio_id_reg <= id_reg[7:0];
      end
      ldr_reg      <= (state_reg == IMC_EXT) ? ldr_of(id_reg) : 32'h0;
      tpr_reg      <= '0;
      dfr_reg      <= IMC_DFR_RST;
      svr_reg      <= IMC_SVR_RST;
      isr_reg      <= '0;
      tmr_reg      <= '0;
      irr_reg      <= '0;
      icr_lo_reg   <= '0;
      icr_hi_reg   <= '0;
      for (int i = 0; i < IMC_LVT_NUM; i++) begin
        lvt_reg[i] <= IMC_LVT_RST;
      end
      init_cnt_reg <= '0;
      cur_cnt_reg  <= '0;
      dcr_reg      <= '0;
      self_reg     <= '0;
    end else if (go_ext) begin
      // derive logical id, reload mmio id from id low byte, clear icr high
      ldr_reg     <= ldr_of(id_reg);
      mmio_id_reg <= id_reg[7:0];
      icr_hi_reg  <= '0;
    end else if (wr_commit) begin
      // one access per cycle in arrival order
      case (acc_ix) inside
        IMC_IX_ID:   mmio_id_reg <= wd[31:24];
        IMC_IX_TPR:  tpr_reg     <= wd[31:0];
        IMC_IX_LDR:  ldr_reg     <= wd[31:0];
        IMC_IX_DFR:  dfr_reg     <= wd[31:0] | ~IMC_DFR_MASK;
        IMC_IX_SVR:  svr_reg     <= wd[31:0];
        IMC_IX_ICR: begin
          icr_lo_reg <= wd[31:0];
          if (!legacy_view) begin
            icr_hi_reg <= wd[63:32];
          end
        end
        IMC_IX_ICR_HI: icr_hi_reg <= wd[31:0];
        IMC_IX_CMCI, [IMC_IX_LVT_FIRST:IMC_IX_LVT_LAST]:
          lvt_reg[lvt_slot(acc_ix)] <= wd[31:0];
        IMC_IX_INIT: begin
          // no countdown here; current count follows the load
          init_cnt_reg <= wd[31:0];
          cur_cnt_reg  <= wd[31:0];
        end
        IMC_IX_DCR:  dcr_reg     <= wd[31:0];
        IMC_IX_SELF: self_reg    <= wd[31:0];
        default: ;
      endcase
    end
  end

  // core answer one cycle after the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_done  <= 1'b0;
      acc_fault <= 1'b0;
      acc_rdata <= '0;
    end else begin
      acc_done  <= acc_valid;
      acc_fault <= acc_valid && acc_bad;
      acc_rdata <= (acc_valid && !acc_write && !acc_bad) ? rd_value : '0;
    end
  end

  logic entry_hit;

  // protected index range in area entry
  assign entry_hit =
      (area_entry_low_word & IMC_ENTRY_MASK) == IMC_ENTRY_MATCH;

  // entry check answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry_done        <= 1'b0;
      entry_fail        <= 1'b0;
      entry_host_reload <= 1'b0;
      entry_abort       <= 1'b0;
    end else begin
      entry_done        <= entry_valid;
      entry_fail        <= entry_valid && entry_hit;
      entry_host_reload <= entry_valid && entry_hit && !entry_exit;
      entry_abort       <= entry_valid && entry_hit && entry_exit;
    end
  end

  logic fault_event;
  logic status_clr;

  assign fault_event = (acc_valid && acc_bad) ||
                       (apb_mode_wr && !base_wr && !apb_mode_ok);
  assign status_clr  = apb_wr && (paddr == IMC_APB_STATUS);

  // sticky flags: a new event beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fault_flag_reg <= 1'b0;
      entry_flag_reg <= 1'b0;
      fault_cnt_reg  <= '0;
    end else begin
      fault_flag_reg <= fault_event ||
          (fault_flag_reg && !(status_clr && pwdata[IMC_ST_FAULT]));
      entry_flag_reg <= (entry_valid && entry_hit) ||
          (entry_flag_reg && !(status_clr && pwdata[IMC_ST_ENTRY]));
      if (fault_event) begin
        fault_cnt_reg <= fault_cnt_reg + 16'h0001;
      end
    end
  end

  // apb read data is prepared in the setup cycle, so no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= '0;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (psel && !penable) begin
        pslverr <= 1'b0;
        unique case (paddr)
          IMC_APB_STATUS: prdata <= {22'h0, entry_flag_reg, fault_flag_reg,
                                     5'h0, state_reg};
          IMC_APB_MODE:   prdata <= {20'h0, mode_enable, mode_extended,
                                     10'h0};
          IMC_APB_ID:     prdata <= id_reg;
          IMC_APB_FCNT:   prdata <= {16'h0, fault_cnt_reg};
          default: begin
            prdata  <= '0;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

endmodule

// ### verif/imc_mode_ctrl_asserts.sv
`timescale 1ns/100ps
module imc_mode_ctrl_chk
  import imc_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // core access
  input wire logic        acc_valid,
  input wire logic        acc_mmio,
  input wire logic        acc_write,
  input wire logic [31:0] acc_addr,
  input wire logic        acc_done,
  input wire logic        acc_fault,
  input wire logic [63:0] acc_rdata,
  // entry check
  input wire logic        entry_valid,
  input wire logic        entry_exit,
  input wire logic [31:0] area_entry_low_word,
  input wire logic        entry_done,
  input wire logic        entry_fail,
  input wire logic        entry_host_reload,
  input wire logic        entry_abort,
  // mode
  input wire logic        mode_enable,
  input wire logic        mode_extended
);
  // single domain, so one clock and one disable for all
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_done_one_cycle: assert property (
    acc_done == $past(acc_valid)) else $error("answer not one cycle late");
  a_fault_with_done: assert property (
    acc_fault |-> acc_done) else $error("fault without answer");
  a_range_off_faults: assert property (
    acc_valid && !acc_mmio && acc_addr[31:10] == 22'h000002 && !mode_extended
    |=> acc_fault) else $error("range access outside extended mode");
  a_mmio_ext_dead: assert property (
    acc_valid && acc_mmio && !acc_write && mode_extended
    |=> !acc_fault && acc_rdata == 64'h0) else $error("mmio live in ext");
  a_id_read_only: assert property (
    acc_valid && !acc_mmio && acc_write && acc_addr == 32'h0000_0802
    |=> acc_fault) else $error("identifier write accepted");
  a_entry_verdict: assert property (
    entry_valid |=> entry_done && entry_fail ==
    ((($past(area_entry_low_word) & IMC_ENTRY_MASK)) == IMC_ENTRY_MATCH))
    else $error("entry verdict wrong");
  a_entry_outcome: assert property (
    entry_done |-> entry_abort == (entry_fail && $past(entry_exit)) &&
    entry_host_reload == (entry_fail && !$past(entry_exit)))
    else $error("entry outcome wrong");
  a_no_invalid: assert property (
    !(mode_extended && !mode_enable)) else $error("invalid mode held");
  a_ext_exit_off: assert property (
    $fell(mode_extended) |-> !mode_enable) else $error("ext left wrongly");
  a_dis_exit_leg: assert property (
    $rose(mode_enable) |-> !mode_extended) else $error("disabled left wrongly");
  a_reset_legacy: assert property (
    $rose(presetn) |-> mode_enable && !mode_extended)
    else $error("reset mode not legacy");
endmodule

bind imc_mode_ctrl imc_mode_ctrl_chk imc_mode_ctrl_chk_inst (
  .pclk(pclk), .presetn(presetn), .acc_valid(acc_valid),
  .acc_mmio(acc_mmio), .acc_write(acc_write), .acc_addr(acc_addr),
  .acc_done(acc_done), .acc_fault(acc_fault), .acc_rdata(acc_rdata),
  .entry_valid(entry_valid), .entry_exit(entry_exit),
  .area_entry_low_word(area_entry_low_word), .entry_done(entry_done),
  .entry_fail(entry_fail), .entry_host_reload(entry_host_reload),
  .entry_abort(entry_abort), .mode_enable(mode_enable),
  .mode_extended(mode_extended)
);

// ### verif/imc_core_model.sv
`timescale 1ns/100ps
module imc_core_model (
  // clock
  input wire logic        pclk,
  // request
  output logic            acc_valid,
  output logic            acc_mmio,
  output logic            acc_write,
  output logic     [31:0] acc_addr,
  output logic     [63:0] acc_wdata,
  // answer
  input wire logic        acc_done,
  input wire logic        acc_fault,
  input wire logic [63:0] acc_rdata
);
  // idle at time zero
  initial begin
    acc_valid = 1'b0;
    acc_mmio  = 1'b0;
    acc_write = 1'b0;
    acc_addr  = 32'h0;
    acc_wdata = 64'h0;
  end

  // one at a time in order
  // no store buffer here, so no fence is ever needed before a write
  task automatic access(input logic m, input logic w, input logic [31:0] a,
                        input logic [63:0] d, output logic [63:0] r,
                        output logic f, output logic ok);
    int n;
    ok = 1'b0;
    r = 64'h0;
    f = 1'b0;
    @(posedge pclk);
    acc_valid <= 1'b1;
    acc_mmio  <= m;
    acc_write <= w;
    acc_addr  <= a;
    acc_wdata <= d;
    @(posedge pclk);
    // released address and data lines show the inverse so stale values never match
    acc_valid <= 1'b0;
    acc_addr  <= ~a;
    acc_wdata <= ~d;
    for (n = 0; n < 8 && !ok; n++) begin
      @(negedge pclk);
      if (acc_done === 1'b1) begin
        ok = 1'b1;
        r = acc_rdata;
        f = acc_fault;
      end
    end
  endtask
endmodule

// ### verif/test_interrupt_unit_mode_control.sv
`timescale 1ns/100ps
module test_interrupt_unit_mode_control;
  import imc_pkg::*;
  localparam logic RD = 1'b0;
  localparam logic WR = 1'b1;
  localparam logic OK = 1'b0;
  localparam logic GP = 1'b1;
  localparam logic [31:0] ID = 32'h1234_5678;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, hw_id, acc_addr, area_entry_low_word;
  logic        acc_valid, acc_mmio, acc_write, acc_done, acc_fault;
  logic [63:0] acc_wdata, acc_rdata;
  logic        soft_init, entry_valid, entry_exit, entry_done, entry_fail;
  logic        entry_host_reload, entry_abort, mode_enable, mode_extended;
  int          fail_count, check_count;

  // 25 MHz clock
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  // every port has a same-named bench signal
  imc_mode_ctrl imc_mode_ctrl_inst (.*);

  imc_core_model imc_core_model_inst (
    .pclk(pclk), .acc_valid(acc_valid), .acc_mmio(acc_mmio),
    .acc_write(acc_write), .acc_addr(acc_addr), .acc_wdata(acc_wdata),
    .acc_done(acc_done), .acc_fault(acc_fault), .acc_rdata(acc_rdata));

  // compare and count
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    if (fail_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // apb transfer, held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      fail_count++;
      final_report();
    end
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic status_is(input logic [2:0] exp);
    logic [31:0] r;
    apb(RD, IMC_APB_STATUS, 32'h0, r);
    chk({61'h0, r[2:0]}, {61'h0, exp});
  endtask

  // core access through the partner, result and fault both compared
  task automatic go(input logic m, input logic w, input logic [31:0] a,
                    input logic [63:0] d, input logic [63:0] er,
                    input logic ef);
    logic [63:0] r;
    logic        f, ok;
    imc_core_model_inst.access(m, w, a, d, r, f, ok);
    if (!ok) begin
      fail_count++;
      final_report();
    end
    chk(r, er);
    chk({63'h0, f}, {63'h0, ef});
  endtask

  task automatic ent(input logic x, input logic [31:0] low, input logic f);
    @(posedge pclk);
    entry_valid <= 1'b1;
    entry_exit <= x;
    area_entry_low_word <= low;
    @(posedge pclk);
    entry_valid <= 1'b0;
    @(negedge pclk);
    chk({entry_done, entry_fail, entry_host_reload, entry_abort},
        {1'b1, f, f & ~x, f & x});
  endtask

  task automatic pulse_init();
    @(posedge pclk);
    soft_init <= 1'b1;
    @(posedge pclk);
    soft_init <= 1'b0;
  endtask

  // main sequence
  initial begin
    logic [31:0] r;
    fail_count = 0;
    check_count = 0;
    {presetn, psel, penable, pwrite, soft_init, entry_valid} = 6'h0;
    {entry_exit, paddr, pwdata, area_entry_low_word} = 77'h0;
    hw_id = ID;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    status_is(3'h2);
    apb(RD, IMC_APB_MODE, 32'h0, r);
    chk(r, 32'h800);
    apb(RD, IMC_APB_ID, 32'h0, r);
    chk(r, ID);
    apb(RD, 12'h010, 32'h0, r);
    chk(pslverr, 1'b1);
    go(RD, RD, 32'h802, 64'h0, 64'h0, GP);
    go(RD, WR, 32'hbff, 64'h0, 64'h0, GP);
    go(WR, RD, 32'h20, 64'h0, 64'h7800_0000, OK);
    go(WR, RD, 32'hf0, 64'h0, 64'hff, OK);
    go(WR, RD, 32'he0, 64'h0, 64'hffff_ffff, OK);
    go(WR, RD, 32'h320, 64'h0, 64'h1_0000, OK);
    go(WR, WR, 32'h80, 64'h33, 64'h0, OK);
    go(WR, RD, 32'h80, 64'h0, 64'h33, OK);
    pulse_init();
    go(WR, RD, 32'h80, 64'h0, 64'h0, OK);
    go(WR, RD, 32'h20, 64'h0, 64'h7800_0000, OK);
    go(RD, WR, 32'h400, 64'h400, 64'h0, GP);
    status_is(3'h2);
    go(WR, WR, 32'hd0, 64'hab00_0000, 64'h0, OK);
    go(WR, WR, 32'h310, 64'hff00_0000, 64'h0, OK);
    go(RD, WR, 32'h400, 64'hc00, 64'h0, OK);
    status_is(3'h4);
    go(RD, RD, 32'h80d, 64'h0, 64'h4567_0100, OK);
    go(RD, RD, 32'h830, 64'h0, 64'h0, OK);
    go(RD, RD, 32'h802, 64'h0, {32'h0, ID}, OK);
    go(WR, RD, 32'hf0, 64'h0, 64'h0, OK);
    go(RD, WR, 32'h802, 64'h1, 64'h0, GP);
    go(RD, WR, 32'h808, 64'h100, 64'h0, GP);
    go(RD, WR, 32'h808, 64'h55, 64'h0, OK);
    go(RD, RD, 32'h808, 64'h0, 64'h55, OK);
    go(RD, WR, 32'h400, 64'h800, 64'h0, GP);
    ent(1'b1, 32'h810, 1'b1);
    ent(1'b0, 32'h8ff, 1'b1);
    ent(1'b0, 32'h7ff, 1'b0);
    ent(1'b1, 32'h1800, 1'b0);
    ent(1'b0, 32'hffff_f800, 1'b0);
    pulse_init();
    status_is(3'h4);
    go(RD, RD, 32'h802, 64'h0, {32'h0, ID}, OK);
    go(RD, RD, 32'h808, 64'h0, 64'h0, OK);
    go(RD, WR, 32'h400, 64'h0, 64'h0, OK);
    status_is(3'h1);
    pulse_init();
    status_is(3'h1);
    go(RD, WR, 32'h400, 64'hc00, 64'h0, GP);
    go(RD, WR, 32'h400, 64'h800, 64'h0, OK);
    go(WR, RD, 32'h20, 64'h0, 64'h7800_0000, OK);
    go(RD, WR, 32'h400, 64'h0, 64'h0, OK);
    status_is(3'h1);
    apb(WR, IMC_APB_MODE, 32'h800, r);
    status_is(3'h2);
    go(RD, WR, 32'h400, 64'hc00, 64'h0, OK);
    @(posedge pclk);
    presetn <= 1'b0;
    hw_id <= 32'h0000_00a5;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    status_is(3'h2);
    apb(RD, IMC_APB_ID, 32'h0, r);
    chk(r, 32'h0000_00a5);
    final_report();
  end
endmodule
